/* File: hw/cvp_dac_map.sv */
// Mapping of a signed velocity to unipolar or bipolar analog codes and direction outputs
`timescale 1ns/1ps
module cvp_dac_map #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Velocity command
  input wire logic [W-1:0] speed,
  input wire logic backward,
  input wire logic moving,
  input wire logic bipolar,
  // Analog and direction outputs
  output logic [W-1:0] dacCode,
  output logic dirFwd,
  output logic dirBwd
);
  logic [W-1:0] half;
  logic [W-1:0] mag;

  initial begin
    if (W < 4) begin
      $error("cvp_dac_map: W too small");
    end
  end

  // Bipolar magnitude uses W-1 bits, offset-free two's complement
  assign half = speed >> 1;
  assign mag = moving ? half : '0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dacCode <= '0;
      dirFwd <= 1'b0;
      dirBwd <= 1'b0;
    end else if (!moving) begin
      dacCode <= '0; // see RQ19
      dirFwd <= 1'b0;
      dirBwd <= 1'b0;
    end else if (bipolar) begin
      dacCode <= backward ? (~mag + 1'b1) : mag; // see RQ11 see RQ14 see RQ16
      dirFwd <= 1'b0;
      dirBwd <= 1'b0;
    end else begin
      dacCode <= speed; // see RQ10 see RQ13
      dirFwd <= !backward; // see RQ15
      dirBwd <= backward;
    end
  end
endmodule

/* File: hw/cvp_profiler.sv */
// Velocity profile generator for a frequency converter with APB register access
// Summary of operation
// RQ1 - Commanded speed never exceeds maximum velocity; after vmax is lowered mid-move the code steps speed down to it
// RQ2 - Speed change per step limited by acceleration
// RQ3 - Shortest move within both limits is aimed
// RQ4 - Ideal ramp uses ten velocity steps
// RQ5 - Positioning and jog share one profile
// RQ6 - Software supplies maximum velocity before start
// RQ7 - Acceleration and stopping distance set beforehand
// RQ8 - Software supplies the switch-off difference
// RQ9 - Start refused when distance within switch-off
// RQ10 - Unipolar: positive analog plus direction outputs
// RQ11 - Bipolar: single signed analog, no direction
// RQ12 - Analog command updated in discrete steps
// RQ13 - Unipolar full scale equals maximum velocity
// RQ14 - Bipolar plus/minus full scale equal maximum
// RQ15 - Exactly one direction output while moving; in bipolar mode the code keeps both low
// RQ16 - Bipolar direction carried by sign only
// RQ17 - Drive removed within switch-off difference
// RQ18 - Completion reported to software
// RQ19 - Zero command and no direction when idle
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module cvp_profiler
  import cvp_pkg::*;
#(
  parameter int STEP_CYC = cvp_pkg::CVP_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Actual position from the encoder logic
  input wire logic [cvp_pkg::CVP_POS_W-1:0] actualPos,
  // Converter outputs
  output logic [cvp_pkg::CVP_DAC_W-1:0] dacCode,
  output logic dirFwd,
  output logic dirBwd
);
  import cvp_pkg::*;

  localparam int PW = CVP_POS_W;
  localparam int DW = CVP_DAC_W;

  initial begin
    if (STEP_CYC < 2) begin
      $error("cvp_profiler: STEP_CYC must be at least 2");
    end
  end

  // Configuration registers
  logic [DW-1:0] vmax;
  logic [15:0] accel;
  logic [PW-1:0] stopDist;
  logic [PW-1:0] swOff;
  logic [PW-1:0] dest;
  logic bipolar;
  // Status
  cvp_mode_e mode;
  logic done;
  logic reject;
  logic backward;
  logic [DW-1:0] speed;
  // Bus decode
  logic wrEn;
  logic rdEn;
  logic addrOk;
  logic ctrlWr;
  logic startReq;
  logic jogFwdReq;
  logic jogBwdReq;
  logic abortReq;
  // Profile terms
  logic tick;
  logic [PW-1:0] remain;
  logic [PW-1:0] startDist;
  logic [DW-1:0] stepSize;
  logic [DW-1:0] next_speed;
  logic [DW:0] sumUp;
  logic decelZone;
  logic [DW-1:0] dacOut;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign addrOk = (paddr[1:0] == 2'b00) && (paddr <= CVP_OFS_DAC);
  assign pslverr = psel && penable && !addrOk;
  assign ctrlWr = wrEn && (paddr == CVP_OFS_CTRL);
  assign startReq = ctrlWr && pwdata[CVP_CTRL_START];
  assign jogFwdReq = ctrlWr && pwdata[CVP_CTRL_JOGFWD];
  assign jogBwdReq = ctrlWr && pwdata[CVP_CTRL_JOGBWD];
  assign abortReq = ctrlWr && pwdata[CVP_CTRL_ABORT];

  // Static configuration written by software before a move
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      vmax <= CVP_VMAX_RST;
      accel <= CVP_ACCEL_RST;
      stopDist <= CVP_STOPDIST_RST;
      swOff <= CVP_SWOFF_RST;
      dest <= '0;
      bipolar <= 1'b0;
    end else if (wrEn) begin
      case (paddr)
        CVP_OFS_CTRL: bipolar <= pwdata[CVP_CTRL_BIPOLAR];
        CVP_OFS_VMAX: vmax <= pwdata[DW-1:0]; // see RQ6
        CVP_OFS_ACCEL: accel <= pwdata[15:0]; // see RQ7
        CVP_OFS_STOPDIST: stopDist <= pwdata[PW-1:0]; // see RQ7
        CVP_OFS_SWOFF: swOff <= pwdata[PW-1:0]; // see RQ8
        CVP_OFS_DEST: dest <= pwdata[PW-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux, unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        CVP_OFS_CTRL: prdata <= {27'h0, bipolar, 4'h0};
        CVP_OFS_STATUS: prdata <= {28'h0, backward, reject, done, mode != CVP_IDLE};
        CVP_OFS_VMAX: prdata <= {20'h0, vmax};
        CVP_OFS_ACCEL: prdata <= {16'h0, accel};
        CVP_OFS_STOPDIST: prdata <= {8'h0, stopDist};
        CVP_OFS_SWOFF: prdata <= {8'h0, swOff};
        CVP_OFS_DEST: prdata <= {8'h0, dest};
        CVP_OFS_ACTUAL: prdata <= {8'h0, actualPos};
        CVP_OFS_DAC: prdata <= {20'h0, dacOut};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  cvp_step_tick #(
    .PERIOD(STEP_CYC)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Distance left to destination in the direction of travel
  assign remain = backward ? (actualPos - dest) : (dest - actualPos);
  // Distance for a new start, direction from the sign of the difference
  assign startDist = (dest >= actualPos) ? (dest - actualPos) : (actualPos - dest);
  // Ramp step: vmax/10 per update, bounded by acceleration
  assign stepSize = (DW'(vmax / DW'(CVP_STEPS)) == '0) ? DW'(1) :
                    ((accel[DW-1:0] != '0) && (accel[DW-1:0] < DW'(vmax / DW'(CVP_STEPS)))) ?
                    accel[DW-1:0] : DW'(vmax / DW'(CVP_STEPS)); // see RQ2 see RQ4
  assign sumUp = {1'b0, speed} + {1'b0, stepSize};
  // Slow down once inside stopping distance plus switch-off difference
  assign decelZone = (mode == CVP_POS) && (remain <= (stopDist + swOff));

  // Next commanded speed, stepped on each tick
  always_comb begin
    next_speed = speed;
    if (decelZone || (speed > vmax)) begin
      next_speed = (speed > stepSize) ? (speed - stepSize) : DW'(1); // see RQ2
      if (speed > vmax && speed - stepSize < vmax) begin
        next_speed = vmax; // see RQ1
      end
    end else if (sumUp > {1'b0, vmax}) begin
      next_speed = vmax; // see RQ1 see RQ3
    end else begin
      next_speed = sumUp[DW-1:0]; // see RQ3
    end
  end

  // Operation sequencer, shared by positioning and jog
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode <= CVP_IDLE;
      speed <= '0;
      backward <= 1'b0;
    end else if (abortReq) begin
      mode <= CVP_IDLE;
      speed <= '0;
    end else begin
      case (mode)
        CVP_IDLE: begin
          speed <= '0;
          if (startReq && (startDist > swOff)) begin // see RQ9
            mode <= CVP_POS;
            backward <= dest < actualPos;
          end else if (jogFwdReq) begin
            mode <= CVP_JOG; // see RQ5
            backward <= 1'b0;
          end else if (jogBwdReq) begin
            mode <= CVP_JOG; // see RQ5
            backward <= 1'b1;
          end
        end
        CVP_POS: begin
          if ((remain <= swOff) || (remain[PW-1])) begin
            mode <= CVP_IDLE; // see RQ17
            speed <= '0;
          end else if (tick) begin
            speed <= next_speed; // see RQ12
          end
        end
        CVP_JOG: begin
          if (tick) begin
            speed <= next_speed; // see RQ12 see RQ5
          end
        end
        default: begin
          mode <= CVP_IDLE;
          speed <= '0;
        end
      endcase
    end
  end

  // Completion and rejection flags; a new event wins over the clearing start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      reject <= 1'b0;
    end else begin
      if (mode == CVP_POS && ((remain <= swOff) || remain[PW-1]) && !abortReq) begin
        done <= 1'b1; // see RQ18
      end else if (startReq || jogFwdReq || jogBwdReq) begin
        done <= 1'b0;
      end
      if (mode == CVP_IDLE && startReq && !abortReq && (startDist <= swOff)) begin
        reject <= 1'b1; // see RQ9
      end else if (startReq || jogFwdReq || jogBwdReq) begin
        reject <= 1'b0;
      end
    end
  end

  cvp_dac_map #(
    .W(DW)
  ) u_map (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .speed(speed),
    .backward(backward),
    .moving(mode != CVP_IDLE),
    .bipolar(bipolar),
    .dacCode(dacOut),
    .dirFwd(dirFwd),
    .dirBwd(dirBwd)
  );

  assign dacCode = dacOut;
endmodule

/* File: hw/cvp_step_tick.sv */
// Divider producing one-cycle step enable pulses
`timescale 1ns/1ps
module cvp_step_tick #(
  parameter int PERIOD = 1000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Enable pulse
  output logic tick
);
  localparam int CW = $clog2(PERIOD + 1);
  logic [CW-1:0] count;

  initial begin
    if (PERIOD < 2) begin
      $error("cvp_step_tick: PERIOD must be at least 2");
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == CW'(PERIOD - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

/* File: shared/cvp_pkg.sv */
// Package with register map, field layout and timing constants of the velocity profiler
package cvp_pkg;
  localparam int CVP_POS_W = 24;
  localparam int CVP_DAC_W = 12;
  localparam int CVP_STEPS = 10;
  // Register byte offsets
  localparam logic [7:0] CVP_OFS_CTRL = 8'h00;
  localparam logic [7:0] CVP_OFS_STATUS = 8'h04;
  localparam logic [7:0] CVP_OFS_VMAX = 8'h08;
  localparam logic [7:0] CVP_OFS_ACCEL = 8'h0C;
  localparam logic [7:0] CVP_OFS_STOPDIST = 8'h10;
  localparam logic [7:0] CVP_OFS_SWOFF = 8'h14;
  localparam logic [7:0] CVP_OFS_DEST = 8'h18;
  localparam logic [7:0] CVP_OFS_ACTUAL = 8'h1C;
  localparam logic [7:0] CVP_OFS_DAC = 8'h20;
  // Control register fields (write one to act; the bipolar bit is stored on every write)
  localparam int CVP_CTRL_START = 0;
  localparam int CVP_CTRL_JOGFWD = 1;
  localparam int CVP_CTRL_JOGBWD = 2;
  localparam int CVP_CTRL_ABORT = 3;
  localparam int CVP_CTRL_BIPOLAR = 4;
  // Status register fields
  localparam int CVP_ST_BUSY = 0;
  localparam int CVP_ST_DONE = 1;
  localparam int CVP_ST_REJECT = 2;
  localparam int CVP_ST_DIRBWD = 3;
  // Reset values
  localparam logic [CVP_DAC_W-1:0] CVP_VMAX_RST = 12'hFFF;
  localparam logic [15:0] CVP_ACCEL_RST = 16'h0001;
  localparam logic [CVP_POS_W-1:0] CVP_STOPDIST_RST = 24'h000000;
  localparam logic [CVP_POS_W-1:0] CVP_SWOFF_RST = 24'h000000;
  // Step period of the analog update: time in us and cycles at 100 MHz
  localparam int CVP_CLK_MHZ = 100;
  localparam int CVP_STEP_US = 10;
  localparam int CVP_STEP_CYC = CVP_STEP_US * CVP_CLK_MHZ;
  typedef enum logic [1:0] {CVP_IDLE, CVP_POS, CVP_JOG} cvp_mode_e;
endpackage

/* File: tb/cvp_converter_model.sv */
// Converter model turning the command into axis travel
`timescale 1ns/1ps
module cvp_converter_model #(
  parameter int SHIFT = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Command
  input wire logic [11:0] dacCode,
  input wire logic dirFwd,
  input wire logic dirBwd,
  input wire logic bipolar,
  // Encoder
  output logic [23:0] actualPos
);
  logic signed [31:0] acc;
  logic signed [31:0] vel;
  always_comb begin
    if (bipolar) vel = 32'(signed'(dacCode));
    else if (dirFwd) vel = {20'h0, dacCode};
    else if (dirBwd) vel = -{20'h0, dacCode};
    else vel = '0;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) acc <= '0;
    else acc <= acc + vel;
  end
  assign actualPos = acc[SHIFT+23:SHIFT];
endmodule

/* File: tb/cvp_profiler_assertions.sv */
// Port checker for the velocity profiler
`timescale 1ns/1ps
module cvp_profiler_assertions #(
  parameter int STEP_CYC = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Converter
  input wire logic [11:0] dacCode,
  input wire logic dirFwd,
  input wire logic dirBwd
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [11:0] prevDac;
  logic [7:0] hold;
  logic rdSet;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prevDac <= 12'h000;
      hold <= 8'h00;
      rdSet <= 1'b0;
    end else begin
      prevDac <= dacCode;
      hold <= (dacCode != prevDac) ? 8'h00 : ((hold == 8'hFF) ? hold : hold + 8'h01);
      rdSet <= psel && !penable && !pwrite;
    end
  end
  chk_dir_onehot: assert property (!(dirFwd && dirBwd))
    else $error("both directions high");
  chk_reset_idle: assert property ($rose(rst_n) |-> dacCode == 12'h000 && !dirFwd && !dirBwd)
    else $error("outputs active after reset");
  chk_drop_zero: assert property (($fell(dirFwd) || $fell(dirBwd)) |-> dacCode == 12'h000)
    else $error("direction dropped with speed left");
  chk_dir_code: assert property (($rose(dirFwd) || $rose(dirBwd)) |-> ##[0:40] dacCode != 12'h000)
    else $error("direction without speed");
  chk_step_hold: assert property (dacCode != prevDac && dacCode != 0 && prevDac != 0 |-> hold >= STEP_CYC - 1)
    else $error("command changed between steps");
  chk_ready_high: assert property (pready)
    else $error("wait state seen");
  chk_err_map: assert property (psel && penable |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h20))
    else $error("error response wrong");
  chk_rd_hold: assert property ($changed(prdata) |-> rdSet)
    else $error("read data moved");
  cover property (dirFwd && dacCode != 12'h000);
  cover property (!dirFwd && !dirBwd && dacCode[11]);
  cover property (pslverr);
endmodule

bind cvp_profiler cvp_profiler_assertions #(.STEP_CYC(STEP_CYC)) cvp_profiler_assertions_i (.clk_sys(clk_sys),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dacCode(dacCode), .dirFwd(dirFwd), .dirBwd(dirBwd));

/* File: tb/tb_top.sv */
// Testbench for the velocity profiler
`timescale 1ns/1ps
module tb_top;
  import cvp_pkg::*;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, dirFwd, dirBwd, bipMode, lastErr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [23:0] actualPos, p0;
  logic [11:0] dacCode, prev;
  int failures, tests_run, n, up, maxd, mx, bwd;
  cvp_profiler #(.STEP_CYC(8)) cvp_profiler_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .actualPos(actualPos), .dacCode(dacCode), .dirFwd(dirFwd), .dirBwd(dirBwd));
  cvp_converter_model cvp_converter_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .dacCode(dacCode),
    .dirFwd(dirFwd), .dirBwd(dirBwd), .bipolar(bipMode), .actualPos(actualPos));
  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (!pready && k < 50);
    if (k >= 50) begin
      failures++;
      wrap_up();
    end
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic t_reset();
    apb(0, CVP_OFS_VMAX, 0);
    check("vmax", 32'hFFF, q);
    apb(0, CVP_OFS_ACCEL, 0);
    check("accel", 32'h1, q);
    check("idle", 0, 32'({dacCode, dirFwd, dirBwd}));
    apb(0, 8'h24, 0);
    check("unmapped err", 32'h1, {31'h0, lastErr});
    check("unmapped data", 32'h0, q);
    $display("reset test done");
  endtask
  task automatic t_pos();
    apb(1, CVP_OFS_VMAX, 32'hA0);
    apb(1, CVP_OFS_ACCEL, 32'h100);
    apb(1, CVP_OFS_STOPDIST, 32'h180);
    apb(1, CVP_OFS_SWOFF, 32'h20);
    apb(1, CVP_OFS_DEST, 32'h1000);
    apb(1, CVP_OFS_CTRL, 32'h1);
    prev = 0;
    {n, up, maxd, mx, bwd} = '0;
    while ((dacCode != 0 || n < 50) && n < 20000) begin
      @(posedge clk_sys);
      n++;
      if (dacCode > prev) up++;
      if (dacCode > prev && dacCode - prev > maxd) maxd = dacCode - prev;
      if (dacCode > mx) mx = dacCode;
      bwd = bwd | dirBwd;
      prev = dacCode;
    end
    if (n >= 20000) begin
      failures++;
      wrap_up();
    end
    check("ramp steps", 10, up);
    check("step size", 16, maxd);
    check("top speed", 32'hA0, mx);
    check("backward seen", 0, bwd);
    check("stop point", 1, 32'(actualPos >= 24'hFE0 && actualPos <= 24'h1000));
    apb(0, CVP_OFS_STATUS, 0);
    check("done", 32'h2, q & 32'h7);
    $display("positioning test done");
  endtask
  task automatic t_reject();
    apb(1, CVP_OFS_DEST, 32'(actualPos) + 32'h10);
    apb(1, CVP_OFS_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys);
    apb(0, CVP_OFS_STATUS, 0);
    check("reject", 32'h4, q & 32'h7);
    check("no move", 0, 32'({dacCode, dirFwd, dirBwd}));
    $display("reject test done");
  endtask
  task automatic t_jog();
    apb(1, CVP_OFS_VMAX, 32'h64);
    apb(1, CVP_OFS_ACCEL, 32'h3);
    apb(1, CVP_OFS_CTRL, 32'h2);
    prev = 0;
    n = 0;
    while (dacCode < 12'h00C && n < 200) begin
      @(posedge clk_sys);
      n++;
      if (dacCode != prev) check("jog step", 32'(prev) + 32'h3, 32'(dacCode));
      prev = dacCode;
    end
    if (n >= 200) begin
      failures++;
      wrap_up();
    end
    check("jog dirs", 32'h2, 32'({dirFwd, dirBwd}));
    apb(1, CVP_OFS_CTRL, 32'h8);
    repeat (4) @(posedge clk_sys);
    check("jog stop", 0, 32'({dacCode, dirFwd, dirBwd}));
    $display("jog test done");
  endtask
  task automatic t_bip();
    p0 = actualPos;
    apb(1, CVP_OFS_VMAX, 32'h200);
    apb(1, CVP_OFS_ACCEL, 32'hFFFF);
    apb(1, CVP_OFS_CTRL, 32'h14);
    bipMode <= 1'b1;
    n = 0;
    while (dacCode !== 12'hF00 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 300) begin
      failures++;
      wrap_up();
    end
    check("bipolar code", 32'hF00, 32'(dacCode));
    check("bipolar dirs", 0, 32'({dirFwd, dirBwd}));
    check("moved back", 1, 32'(actualPos < p0));
    apb(1, CVP_OFS_CTRL, 32'h18);
    repeat (4) @(posedge clk_sys);
    check("bipolar stop", 0, 32'(dacCode));
    $display("bipolar test done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, psel, penable, pwrite, bipMode, paddr, pwdata} = '0;
    failures = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_pos();
    t_reject();
    t_jog();
    t_bip();
    wrap_up();
  end
endmodule
